//--- src/gec_change_det.sv
module gec_change_det
  import gec_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] arm,
  output logic      [W-1:0] change
);

  logic [W-1:0] prev;
  logic [W-1:0] next_prev;
  logic         primed;

  // ----------------------------------------------------------------
  // Level history
  // ----------------------------------------------------------------
  // First cycle after reset only samples, so a high input is not
  // mistaken for a transition out of the reset value.
  always_comb
  begin
    next_prev = level;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev   <= '0;
      primed <= 1'b0;
    end
    else
    begin
      prev   <= next_prev;
      primed <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      assign change[i] = primed & arm[i] & (level[i] ^ prev[i]);
    end
  endgenerate

endmodule

//--- src/gec_pkg.sv
package gec_pkg;

  // ----------------------------------------------------------------
  // Configuration space byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  GEC_OFS_CTRL_LO   = 8'h86;
  localparam logic [7:0]  GEC_OFS_CTRL_HI   = 8'h87;
  localparam logic [7:0]  GEC_OFS_STATUS    = 8'h88;
  localparam logic [7:0]  GEC_OFS_ENABLE    = 8'h89;

  // ----------------------------------------------------------------
  // General control layout and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] GEC_CTRL_RESET    = 16'h0003;
  // Bits that only the global reset clears
  localparam logic [15:0] GEC_CTRL_STICKY   = 16'h5c80;
  localparam int          GEC_BIT_STYLE     = 14;
  localparam int          GEC_BIT_LIMIT     = 12;
  localparam int          GEC_BIT_BASE      = 11;
  localparam int          GEC_BIT_SWITCH    = 10;
  localparam int          GEC_BIT_SC_OFF    = 7;
  localparam int          GEC_ARB_LSB       = 0;

  typedef enum logic [1:0] {
    GEC_ARB_OHCI   = 2'h0,
    GEC_ARB_CARD   = 2'h1,
    GEC_ARB_RSVD   = 2'h2,
    GEC_ARB_ROUND  = 2'h3
  } gec_arb_t;

  // ----------------------------------------------------------------
  // Event status and enable layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  GEC_STAT_RESET    = 8'h00;
  localparam logic [7:0]  GEC_EN_RESET      = 8'h00;
  localparam logic [7:0]  GEC_EVT_MASK      = 8'hdf;
  localparam int          GEC_BIT_PWR       = 7;
  localparam int          GEC_BIT_VPP       = 6;
  localparam int          GEC_BIT_RSVD      = 5;
  localparam int          GEC_NUM_GPIN      = 5;
  localparam int          GEC_PWR_W         = 4;

endpackage

//--- src/gec_regs.sv
// Behaviour
// RL1 - Two-bit field picks arbitration: 00 OHCI, 01 card bus, 11 round robin.
// RL2 - Control bit 14 picks smart card interface: 0 EMV, 1 legacy style.
// RL3 - Limit-select bit one makes bit 0 of I/O limit registers read one.
// RL4 - Base-select bit one makes bit 0 of I/O base registers read one.
// RL5 - Control bit 10 picks power switch: 0 is 1.8 V, 1 is 12 V.
// RL6 - Control bit 7 set turns the smart card function fully off.
// RL7 - Reserved control bits are plain read/write storage without effect.
// RL8 - Bits 14,12,11,10,7 and event flags cleared only by global reset.
// RL9 - Status bit 7 sets when socket power state is changed.
// RL10 - Status bit 6 sets when requested Vpp moves to or from 12 V.
// RL11 - Input flags set on level change of pins configured as inputs.
// RL12 - Status bit 5 reads zero and ignores writes.
// RL13 - Event flags are sticky until cleared and reset to zero.
// RL14 - Event output, active low, signals when event flags are set.
// RL15 - Event output only for flags whose enable bit is set.
// RL16 - Writing one clears a flag, writing zero leaves it.
module gec_regs
  import gec_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    bus_reset_n,
  input  wire logic [7:0]              cfg_addr,
  input  wire logic                    cfg_wr,
  input  wire logic                    cfg_rd,
  input  wire logic [7:0]              cfg_wdata,
  output logic      [7:0]              cfg_rdata,
  input  wire logic [GEC_PWR_W-1:0]    socket_power_state,
  input  wire logic                    vpp_is_12v,
  input  wire logic [GEC_NUM_GPIN-1:0] multipin_level,
  input  wire logic [GEC_NUM_GPIN-1:0] multipin_is_input,
  output logic      [1:0]              arbitration_priority,
  output logic                         smartcard_style_choice,
  output logic                         power_switch_type,
  output logic                         smartcard_off,
  output logic                         io_limit_bit0,
  output logic                         io_base_bit0,
  output logic                         general_event_out_n
);

  logic [15:0]              ctrl;
  logic [15:0]              next_ctrl;
  logic [7:0]               stat;
  logic [7:0]               next_stat;
  logic [7:0]               evt_en;
  logic [7:0]               next_evt_en;
  logic [7:0]               next_rdata;
  logic                     next_event_n;
  logic [GEC_PWR_W-1:0]     pwr_prev;
  logic                     vpp_prev;
  logic                     pwr_chg;
  logic                     vpp_chg;
  logic                     state_primed;
  logic [GEC_NUM_GPIN-1:0]  gp_chg;
  logic [7:0]               set_bits;
  logic [7:0]               clr_bits;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  gec_change_det #(.W(GEC_NUM_GPIN)) u_gpin_det
  (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .level  (multipin_level),
    .arm    (multipin_is_input),
    .change (gp_chg)                                      // see RL11
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_prev     <= '0;
      vpp_prev     <= 1'b0;
      state_primed <= 1'b0;
    end
    else
    begin
      pwr_prev     <= socket_power_state;
      vpp_prev     <= vpp_is_12v;
      state_primed <= 1'b1;
    end
  end

  assign pwr_chg = state_primed & (pwr_prev != socket_power_state); // see RL9
  assign vpp_chg = state_primed & (vpp_prev != vpp_is_12v);        // see RL10
  // Flag 5 never sets
  assign set_bits = {pwr_chg, vpp_chg, 1'b0, gp_chg};      // see RL12
  assign clr_bits = (cfg_wr && hit(cfg_addr, GEC_OFS_STATUS)) ?
                    (cfg_wdata & GEC_EVT_MASK) : 8'h00;     // see RL16

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ctrl   = ctrl;
    next_evt_en = evt_en;
    // Bus reset restores only the bits that are not sticky
    if (!bus_reset_n)
      next_ctrl = (ctrl & GEC_CTRL_STICKY)
                | (GEC_CTRL_RESET & ~GEC_CTRL_STICKY);      // see RL8
    else if (cfg_wr && hit(cfg_addr, GEC_OFS_CTRL_LO))
      next_ctrl[7:0] = cfg_wdata;                           // see RL7
    else if (cfg_wr && hit(cfg_addr, GEC_OFS_CTRL_HI))
      next_ctrl[15:8] = cfg_wdata;                          // see RL7
    else if (cfg_wr && hit(cfg_addr, GEC_OFS_ENABLE))
      next_evt_en = cfg_wdata & GEC_EVT_MASK;               // see RL15
    // Set wins over a clear in the same cycle
    next_stat = ((stat & ~clr_bits) | set_bits)
              & GEC_EVT_MASK;                               // see RL13
    next_event_n = ~|(next_stat & next_evt_en);             // see RL14
    if (!cfg_rd)
      next_rdata = cfg_rdata;
    else if (hit(cfg_addr, GEC_OFS_CTRL_LO))
      next_rdata = ctrl[7:0];
    else if (hit(cfg_addr, GEC_OFS_CTRL_HI))
      next_rdata = ctrl[15:8];
    else if (hit(cfg_addr, GEC_OFS_STATUS))
      next_rdata = stat;
    else if (hit(cfg_addr, GEC_OFS_ENABLE))
      next_rdata = evt_en;
    else
      next_rdata = 8'h00;
  end

  // Only the global reset reaches flags and sticky bits
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl                <= GEC_CTRL_RESET;
      stat                <= GEC_STAT_RESET;                // see RL13
      evt_en              <= GEC_EN_RESET;
      cfg_rdata           <= 8'h00;
      general_event_out_n <= 1'b1;
    end
    else
    begin
      ctrl                <= next_ctrl;
      stat                <= next_stat;
      evt_en              <= next_evt_en;
      cfg_rdata           <= next_rdata;
      general_event_out_n <= next_event_n;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // Code 10 is passed through; the arbiter treats it as it likes
  assign arbitration_priority   = ctrl[GEC_ARB_LSB +: 2];  // see RL1
  assign smartcard_style_choice = ctrl[GEC_BIT_STYLE];     // see RL2
  assign io_limit_bit0          = ctrl[GEC_BIT_LIMIT];     // see RL3
  assign io_base_bit0           = ctrl[GEC_BIT_BASE];      // see RL4
  assign power_switch_type      = ctrl[GEC_BIT_SWITCH];    // see RL5
  assign smartcard_off          = ctrl[GEC_BIT_SC_OFF];    // see RL6

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_ARB_WRITE: assert property (                         // see RL1
    cfg_wr && bus_reset_n && hit(cfg_addr, GEC_OFS_CTRL_LO)
    |=> arbitration_priority == $past(cfg_wdata[1:0]))
    else $error("arbitration field not written");
  AST_STYLE: assert property (                             // see RL2
    cfg_wr && bus_reset_n && hit(cfg_addr, GEC_OFS_CTRL_HI)
    |=> smartcard_style_choice == $past(cfg_wdata[6]))
    else $error("style bit not written");
  AST_LIMIT_BASE: assert property (                        // see RL3
    cfg_wr && bus_reset_n && hit(cfg_addr, GEC_OFS_CTRL_HI)
    |=> io_limit_bit0 == $past(cfg_wdata[4])
        && io_base_bit0 == $past(cfg_wdata[3]))
    else $error("I/O select bits wrong");
  AST_STICKY: assert property (                            // see RL8
    !bus_reset_n |=> smartcard_off == $past(smartcard_off)
      && power_switch_type == $past(power_switch_type)
      && arbitration_priority == GEC_ARB_ROUND)
    else $error("bus reset touched sticky bits");
  AST_PWR_SET: assert property (                           // see RL9
    pwr_chg |=> stat[GEC_BIT_PWR])
    else $error("power flag missed");
  AST_VPP_SET: assert property (                           // see RL10
    vpp_chg |=> stat[GEC_BIT_VPP])
    else $error("vpp flag missed");
  AST_GP_SET: assert property (                            // see RL11
    multipin_is_input[0] && state_primed
    && $changed(multipin_level[0]) |=> stat[0])
    else $error("input flag missed");
  AST_RSVD_ZERO: assert property (                         // see RL12
    cfg_rd && hit(cfg_addr, GEC_OFS_STATUS) |=> !cfg_rdata[GEC_BIT_RSVD])
    else $error("reserved status bit read one");
  AST_HOLD: assert property (                              // see RL13
    stat[1] && !clr_bits[1] |=> stat[1])
    else $error("flag dropped without clear");
  AST_EVENT: assert property (                             // see RL15
    general_event_out_n == !(|(stat & evt_en)))
    else $error("event output wrong");
  AST_W1C: assert property (                               // see RL16
    stat[0] && clr_bits[0] && !set_bits[0] |=> !stat[0])
    else $error("write one did not clear");
  AST_SET_WINS: assert property (                          // see RL13
    set_bits[0] && clr_bits[0] |=> stat[0])
    else $error("clear beat a same-cycle set");
  AST_SWITCH: assert property (                            // see RL5
    cfg_wr && bus_reset_n && hit(cfg_addr, GEC_OFS_CTRL_HI)
    |=> power_switch_type == $past(cfg_wdata[2]))
    else $error("switch type bit not written");
  AST_SC_OFF: assert property (                            // see RL6
    cfg_wr && bus_reset_n && hit(cfg_addr, GEC_OFS_CTRL_LO)
    |=> smartcard_off == $past(cfg_wdata[7]))
    else $error("smart card disable bit not written");

  COV_PWR: cover property (pwr_chg ##1 !general_event_out_n);
  COV_CLR: cover property (stat[GEC_BIT_VPP] ##1 !stat[GEC_BIT_VPP]);
  COV_BUSRST: cover property (!bus_reset_n && smartcard_off);
  COV_GP: cover property (gp_chg[4] && clr_bits[4]);

endmodule

//--- verif/testbench.sv
module testbench
  import gec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Signals and device
  // ------------------------------------------------------------
  logic                    mclk;
  logic                    rst_n;
  logic                    bus_reset_n;
  logic [7:0]              cfg_addr;
  logic                    cfg_wr;
  logic                    cfg_rd;
  logic [7:0]              cfg_wdata;
  logic [7:0]              cfg_rdata;
  logic [GEC_PWR_W-1:0]    socket_power_state;
  logic                    vpp_is_12v;
  logic [GEC_NUM_GPIN-1:0] multipin_level;
  logic [GEC_NUM_GPIN-1:0] multipin_is_input;
  logic [1:0]              arbitration_priority;
  logic                    smartcard_style_choice;
  logic                    power_switch_type;
  logic                    smartcard_off;
  logic                    io_limit_bit0;
  logic                    io_base_bit0;
  logic                    general_event_out_n;
  int                      mismatches;
  int                      cmp_count;

  gec_regs i_dut (
    .mclk, .rst_n, .bus_reset_n, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata,
    .cfg_rdata, .socket_power_state, .vpp_is_12v, .multipin_level,
    .multipin_is_input, .arbitration_priority, .smartcard_style_choice,
    .power_switch_type, .smartcard_off, .io_limit_bit0, .io_base_bit0,
    .general_event_out_n
  );

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_wr    <= 1'b1;
    @(posedge mclk);
    cfg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    cfg_addr <= a;
    cfg_rd   <= 1'b1;
    @(posedge mclk);
    cfg_rd   <= 1'b0;
    #1;
    chk($sformatf("read %h", a), exp, cfg_rdata);
  endtask

  // Packs the control outputs and the event line for one compare
  task automatic outs(input logic [7:0] exp);
    chk("outputs", exp, {arbitration_priority, smartcard_style_choice,
        io_limit_bit0, io_base_bit0, power_switch_type, smartcard_off,
        general_event_out_n});
  endtask

  task automatic pulse_bus_reset();
    @(posedge mclk);
    bus_reset_n <= 1'b0;
    @(posedge mclk);
    bus_reset_n <= 1'b1;
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // The whole sequence needs under a hundred cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    end_sim();
  end

  initial
  begin
    rst_n = 1'b0;
    bus_reset_n = 1'b1;
    cfg_addr = 8'h00;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_wdata = 8'h00;
    socket_power_state = 4'h0;
    vpp_is_12v = 1'b0;
    multipin_level = 5'h00;
    multipin_is_input = 5'h1b;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h86, 8'h03);
    rd(8'h87, 8'h00);
    rd(8'h88, 8'h00);
    rd(8'h89, 8'h00);
    rd(8'h90, 8'h00);
    outs(8'hc1);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h86, 8'(i));
      chk("arbitration", 8'(i), {6'h00, arbitration_priority});
      rd(8'h86, 8'(i));
    end
    wr(8'h87, 8'hff);
    wr(8'h86, 8'hfc);
    rd(8'h87, 8'hff);
    rd(8'h86, 8'hfc);
    outs(8'h3f);
    // Bus reset keeps only the global-reset bits 14,12,11,10,7
    pulse_bus_reset();
    rd(8'h87, 8'h5c);
    rd(8'h86, 8'h83);
    outs(8'hff);
    wr(8'h89, 8'hff);
    rd(8'h89, 8'hdf);
    @(posedge mclk);
    multipin_level <= 5'h1f;
    socket_power_state <= 4'h5;
    vpp_is_12v <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("event out", 8'h00, {7'h00, general_event_out_n});
    rd(8'h88, 8'hdb);
    wr(8'h88, 8'h20);
    rd(8'h88, 8'hdb);
    pulse_bus_reset();
    rd(8'h88, 8'hdb);
    wr(8'h88, 8'hff);
    rd(8'h88, 8'h00);
    chk("event out", 8'h01, {7'h00, general_event_out_n});
    // Only flag 0 may drive the event line now
    wr(8'h89, 8'h01);
    @(posedge mclk);
    multipin_level <= 5'h1d;
    repeat (3) @(posedge mclk);
    #1;
    chk("masked out", 8'h01, {7'h00, general_event_out_n});
    rd(8'h88, 8'h02);
    @(posedge mclk);
    multipin_level <= 5'h1c;
    repeat (3) @(posedge mclk);
    #1;
    chk("enabled out", 8'h00, {7'h00, general_event_out_n});
    // Flag 0 sets in the very cycle that software clears it
    @(posedge mclk);
    multipin_level <= 5'h1d;
    cfg_addr       <= 8'h88;
    cfg_wdata      <= 8'h01;
    cfg_wr         <= 1'b1;
    @(posedge mclk);
    cfg_wr         <= 1'b0;
    rd(8'h88, 8'h03);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h88, 8'h00);
    rd(8'h89, 8'h00);
    rd(8'h87, 8'h00);
    rd(8'h86, 8'h03);
    outs(8'hc1);
    end_sim();
  end
endmodule
